// ==== hdl/pmcg_pkg.sv ====
// Constants and types for the power mode and clock gating unit
package pmcg_pkg;
	localparam logic [31:0] PWR_OFFSET    = 32'hE01FC0C0;
	localparam logic [31:0] GATE_OFFSET   = 32'hE01FC0C4;
	localparam logic [7:0]  PWR_RESET     = 8'h00;
	localparam logic [31:0] GATE_RESET    = 32'h001817BE;
	localparam logic [7:0]  PWR_MASK      = 8'h03;
	localparam logic [31:0] GATE_MASK     = 32'h3008179E;
	localparam int          PWR_IDLE_BIT  = 0;
	localparam int          PWR_PD_BIT    = 1;
	localparam int          GATE_TIM0     = 1;
	localparam int          GATE_TIM1     = 2;
	localparam int          GATE_SER0     = 3;
	localparam int          GATE_SER1     = 4;
	localparam int          GATE_TW0      = 7;
	localparam int          GATE_SPI      = 8;
	localparam int          GATE_CAL      = 9;
	localparam int          GATE_SSP      = 10;
	localparam int          GATE_CONV     = 12;
	localparam int          GATE_TW1      = 19;
	localparam int          GATE_TIM2     = 28;
	localparam int          GATE_TIM3     = 29;
	localparam int          WAKE_CLOCKS   = 16;
	// Controller registers on the software bus
	localparam logic [7:0]  AV_CTRL       = 8'h00;
	localparam logic [7:0]  AV_WDATA      = 8'h04;
	localparam logic [7:0]  AV_RDATA      = 8'h08;
	localparam logic [7:0]  AV_STATUS     = 8'h0C;
	localparam logic [7:0]  AV_CONV       = 8'h10;
	localparam int          CTRL_GO       = 0;
	localparam int          CTRL_WRITE    = 1;
	localparam int          CTRL_GATE_SEL = 2;

	typedef enum logic [2:0] {
		MODE_HOLD  = 3'h0,
		MODE_RUN   = 3'h1,
		MODE_IDLE  = 3'h2,
		MODE_PDOWN = 3'h3,
		MODE_WAKE  = 3'h4
	} pmcg_mode_type;
endpackage : pmcg_pkg

// ==== hdl/pmcg_if.sv ====
// Link between the power unit and the processor-side controller
`timescale 1ns/1ps
interface pmcg_if;
	import pmcg_pkg::*;
	logic          reg_sel;
	logic          reg_wr;
	logic [31:0]   reg_addr;
	logic [31:0]   reg_wdata;
	logic [31:0]   reg_rdata;
	logic          reg_ack;
	logic          int_req;
	logic          processor_clock_en;
	logic          sys_rst;
	pmcg_mode_type mode;

	modport dev (
		input  reg_sel, reg_wr, reg_addr, reg_wdata, int_req,
		output reg_rdata, reg_ack, processor_clock_en, sys_rst, mode
	);
	modport host (
		output reg_sel, reg_wr, reg_addr, reg_wdata, int_req,
		input  reg_rdata, reg_ack, processor_clock_en, sys_rst, mode
	);
endinterface : pmcg_if

// ==== hdl/pmcg_device.sv ====
// Power mode sequencer, peripheral clock gates and reset hold
//
// Our own choice: the Avalon-MM register port.
`timescale 1ns/1ps
module pmcg_device
	import pmcg_pkg::*;
#(
	parameter int WAKE_CNT = WAKE_CLOCKS
)(
	// Clock and reset
	input  wire logic        core_clk_i,
	input  wire logic        srst_i,
	// Link to the processor side
	pmcg_if.dev              lk,
	// Wake and reset sources
	input  wire logic        ext_wake_i,
	input  wire logic        cal_wake_i,
	input  wire logic        cal_32k_i,
	input  wire logic        pin_rst_i,
	input  wire logic        wdt_rst_i,
	input  wire logic        osc_ready_i,
	input  wire logic        init_done_i,
	// Clock tree controls
	output logic             osc_en_o,
	output logic             base_clk_en_o,
	output logic [31:0]      periph_clk_en_o,
	output logic             mult_off_o,
	output logic             pin_hold_o
);
	localparam int CW = $clog2(WAKE_CNT + 1);
	localparam logic [CW-1:0] CNT_LOAD = CW'(WAKE_CNT);
	localparam logic [CW-1:0] CNT_ZERO = '0;
	localparam logic [CW-1:0] CNT_ONE  = CW'(1);

	typedef struct packed {
		pmcg_mode_type mode;
		logic [7:0]    pwr;
		logic [31:0]   gates;
		logic [CW-1:0] cnt;
		logic          ack;
		logic [31:0]   rdata;
		logic          proc_en;
		logic          osc_en;
		logic          base_en;
		logic [31:0]   periph_en;
		logic          mult_off;
		logic          pin_hold;
		logic          sys_rst;
	} pmcg_dev_state_type;

	pmcg_dev_state_type s_r;
	pmcg_dev_state_type s_nxt;

	function automatic logic pmcg_hit(input logic [31:0] addr, input logic [31:0] off);
		pmcg_hit = (addr == off);
	endfunction : pmcg_hit

	logic rst_req;
	logic clkless_wake;
	logic idle_wake;

	assign rst_req      = pin_rst_i | wdt_rst_i;
	// Only sources that work with the core clock stopped may end power-down
	assign clkless_wake = ext_wake_i | (cal_wake_i & cal_32k_i);
	assign idle_wake    = lk.int_req | ext_wake_i | cal_wake_i;

	always_comb
	begin
		s_nxt          = s_r;
		s_nxt.ack      = 1'b0;
		s_nxt.mult_off = 1'b0;
		case (s_r.mode)
			MODE_HOLD:
			begin
				// Internal reset stays until every release condition is met
				if (s_r.cnt != CNT_ZERO)
				begin
					s_nxt.cnt = s_r.cnt - CNT_ONE;
				end
				else if (osc_ready_i && init_done_i)
				begin
					s_nxt.mode = MODE_RUN;
				end
			end
			MODE_RUN:
			begin
				if (s_r.pwr[PWR_PD_BIT])
				begin
					s_nxt.mode     = MODE_PDOWN;
					s_nxt.mult_off = 1'b1;
				end
				else if (s_r.pwr[PWR_IDLE_BIT])
				begin
					s_nxt.mode = MODE_IDLE;
				end
				// Registers only answer while the processor runs
				if (lk.reg_sel && !s_r.ack)
				begin
					s_nxt.ack   = 1'b1;
					s_nxt.rdata = '0;
					if (pmcg_hit(lk.reg_addr, PWR_OFFSET))
					begin
						if (lk.reg_wr)
						begin
							s_nxt.pwr = lk.reg_wdata[7:0] & PWR_MASK;
						end
						s_nxt.rdata = {24'h000000, s_r.pwr};
					end
					else if (pmcg_hit(lk.reg_addr, GATE_OFFSET))
					begin
						if (lk.reg_wr)
						begin
							s_nxt.gates = lk.reg_wdata;
						end
						// Reserved positions give back whatever was stored
						s_nxt.rdata = s_r.gates;
					end
				end
			end
			MODE_IDLE:
			begin
				// Execution stays halted until an interrupt, external wake or calendar wake arrives
				if (idle_wake)
				begin
					s_nxt.mode                = MODE_RUN;
					s_nxt.pwr[PWR_IDLE_BIT]   = 1'b0;
				end
			end
			MODE_PDOWN:
			begin
				// Gate and power registers are not touched here
				if (clkless_wake)
				begin
					s_nxt.mode = MODE_WAKE;
					s_nxt.cnt  = CNT_LOAD;
				end
			end
			MODE_WAKE:
			begin
				if (s_r.cnt != CNT_ZERO)
				begin
					s_nxt.cnt = s_r.cnt - CNT_ONE;
				end
				else if (osc_ready_i)
				begin
					// Clock returns only at a whole instruction boundary
					s_nxt.mode = MODE_RUN;
					s_nxt.pwr  = PWR_RESET;
				end
			end
			default:
			begin
				s_nxt.mode = MODE_HOLD;
			end
		endcase

		if (srst_i || rst_req)
		begin
			s_nxt.mode  = MODE_HOLD;
			s_nxt.cnt   = CNT_LOAD;
			s_nxt.pwr   = PWR_RESET;
			s_nxt.gates = GATE_RESET;
			s_nxt.ack   = 1'b0;
			s_nxt.rdata = '0;
			// A reset during power-down entry must not leave the multiplier pulse behind
			s_nxt.mult_off = 1'b0;
		end

		s_nxt.proc_en  = (s_nxt.mode == MODE_RUN);
		s_nxt.osc_en   = (s_nxt.mode != MODE_PDOWN);
		// Always-on group keeps running except in power-down and during the wake-up count
		s_nxt.base_en  = (s_nxt.mode != MODE_PDOWN) && (s_nxt.mode != MODE_WAKE);
		s_nxt.periph_en = s_nxt.base_en ? (s_nxt.gates & GATE_MASK) : '0;
		s_nxt.pin_hold = (s_nxt.mode == MODE_PDOWN) || (s_nxt.mode == MODE_WAKE);
		s_nxt.sys_rst  = (s_nxt.mode == MODE_HOLD);
	end

	always_ff @(posedge core_clk_i)
	begin
		if (srst_i)
		begin
			s_r           <= '0;
			s_r.mode      <= MODE_HOLD;
			s_r.cnt       <= CNT_LOAD;
			s_r.pwr       <= PWR_RESET;
			s_r.gates     <= GATE_RESET;
			s_r.osc_en    <= 1'b1;
			s_r.base_en   <= 1'b1;
			s_r.periph_en <= GATE_RESET & GATE_MASK;
			s_r.sys_rst   <= 1'b1;
		end
		else
		begin
			s_r <= s_nxt;
		end
	end

	assign lk.reg_ack            = s_r.ack;
	assign lk.reg_rdata          = s_r.rdata;
	assign lk.processor_clock_en = s_r.proc_en;
	assign lk.sys_rst            = s_r.sys_rst;
	assign lk.mode               = s_r.mode;
	assign osc_en_o              = s_r.osc_en;
	assign base_clk_en_o         = s_r.base_en;
	assign periph_clk_en_o       = s_r.periph_en;
	assign mult_off_o            = s_r.mult_off;
	assign pin_hold_o            = s_r.pin_hold;
endmodule : pmcg_device

// ==== hdl/pmcg_host.sv ====
// Processor-side controller: Avalon-MM command registers driving the link
`timescale 1ns/1ps
module pmcg_host
	import pmcg_pkg::*;
(
	// Clock and reset
	input  wire logic        core_clk_i,
	input  wire logic        srst_i,
	// Link to the power unit
	pmcg_if.host             lk,
	// Avalon-MM slave
	input  wire logic [7:0]  avs_address_i,
	input  wire logic        avs_read_i,
	input  wire logic        avs_write_i,
	input  wire logic [31:0] avs_writedata_i,
	output logic [31:0]      avs_readdata_o,
	output logic             avs_waitrequest_o,
	// Core side
	input  wire logic        int_req_i,
	output logic             proc_clk_en_o,
	output logic             sys_rst_o,
	output logic             conv_power_o
);
	typedef struct packed {
		logic        wait_n;
		logic [31:0] rdata;
		logic        busy;
		logic        sel;
		logic        wr;
		logic        gate_sel;
		logic [31:0] wdata;
		logic [31:0] result;
		logic [31:0] shadow;
		logic        conv;
		logic        irq;
		logic        proc_en;
		logic        sys_rst;
	} pmcg_host_state_type;

	pmcg_host_state_type s_r;
	pmcg_host_state_type s_nxt;
	logic                req;

	assign req = avs_read_i | avs_write_i;

	always_comb
	begin
		s_nxt         = s_r;
		s_nxt.wait_n  = req && !s_r.wait_n;
		s_nxt.irq     = int_req_i;
		s_nxt.proc_en = lk.processor_clock_en;
		s_nxt.sys_rst = lk.sys_rst;
		if (s_r.sel && lk.reg_ack)
		begin
			s_nxt.sel    = 1'b0;
			s_nxt.busy   = 1'b0;
			s_nxt.result = lk.reg_rdata;
			if (s_r.wr && s_r.gate_sel)
			begin
				s_nxt.shadow = s_r.wdata;
			end
		end
		if (req && !s_r.wait_n)
		begin
			s_nxt.rdata = '0;
			case (avs_address_i)
				AV_CTRL:
				begin
					if (avs_write_i && avs_writedata_i[CTRL_GO] && !s_r.busy)
					begin
						s_nxt.busy     = 1'b1;
						s_nxt.sel      = 1'b1;
						s_nxt.wr       = avs_writedata_i[CTRL_WRITE];
						s_nxt.gate_sel = avs_writedata_i[CTRL_GATE_SEL];
						// Ones never reach reserved positions
						s_nxt.wdata    = s_r.wdata & (avs_writedata_i[CTRL_GATE_SEL] ?
							GATE_MASK : {24'h000000, PWR_MASK});
						// Converter gate may not drop while its power is on
						if (avs_writedata_i[CTRL_GATE_SEL] && s_r.conv)
						begin
							s_nxt.wdata[GATE_CONV] = 1'b1;
						end
					end
				end
				AV_WDATA:
				begin
					if (avs_write_i)
					begin
						s_nxt.wdata = avs_writedata_i;
					end
					s_nxt.rdata = s_r.wdata;
				end
				AV_RDATA:
				begin
					s_nxt.rdata = s_r.result;
				end
				AV_STATUS:
				begin
					s_nxt.rdata = {28'h0000000, lk.mode, s_r.busy};
				end
				AV_CONV:
				begin
					// Power enable rises only with the converter clock on
					if (avs_write_i)
					begin
						s_nxt.conv = avs_writedata_i[0] & s_r.shadow[GATE_CONV];
					end
					s_nxt.rdata = {31'h0, s_r.conv};
				end
				default:
				begin
					s_nxt.rdata = '0;
				end
			endcase
		end
		if (lk.sys_rst)
		begin
			s_nxt.shadow = GATE_RESET;
			s_nxt.conv   = 1'b0;
		end
	end

	always_ff @(posedge core_clk_i)
	begin
		if (srst_i)
		begin
			s_r        <= '0;
			s_r.shadow <= GATE_RESET;
			s_r.sys_rst <= 1'b1;
		end
		else
		begin
			s_r <= s_nxt;
		end
	end

	assign avs_waitrequest_o = !s_r.wait_n;
	assign avs_readdata_o    = s_r.rdata;
	assign proc_clk_en_o     = s_r.proc_en;
	assign sys_rst_o         = s_r.sys_rst;
	assign conv_power_o      = s_r.conv;
	assign lk.reg_sel        = s_r.sel;
	assign lk.reg_wr         = s_r.wr;
	assign lk.reg_addr       = s_r.gate_sel ? GATE_OFFSET : PWR_OFFSET;
	assign lk.reg_wdata      = s_r.wdata;
	assign lk.int_req        = s_r.irq;
endmodule : pmcg_host

// ==== sim/pmcg_properties.sv ====
// Concurrent checks on the link between the power unit and its controller
`timescale 1ns/1ps
module pmcg_properties
	import pmcg_pkg::*;
#(
	parameter int WAKE_CNT = WAKE_CLOCKS
)(
	// Clock and reset
	input wire logic          core_clk_i,
	input wire logic          srst_i,
	// Link signals
	input wire logic          reg_sel,
	input wire logic          reg_wr,
	input wire logic [31:0]   reg_addr,
	input wire logic [31:0]   reg_wdata,
	input wire logic          reg_ack,
	input wire logic          int_req,
	input wire logic          processor_clock_en,
	input wire logic          sys_rst,
	input wire pmcg_mode_type mode
);
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (srst_i);
	logic [7:0] wake_len_r;
	wire        pwr_wr = reg_ack && reg_wr && reg_addr == PWR_OFFSET;
	// Cycles spent so far in the wake-up count
	always_ff @(posedge core_clk_i)
	begin
		if (srst_i || mode != MODE_WAKE)
			wake_len_r <= 8'h00;
		else
			wake_len_r <= wake_len_r + 8'h01;
	end
	a_ack_single_pulse: assert property (reg_ack |=> !reg_ack) else $error("ack longer than one cycle");
	a_ack_after_sel: assert property (reg_ack |-> $past(reg_sel) && $past(mode) == MODE_RUN)
		else $error("ack without a request in run");
	a_clk_run_only: assert property (processor_clock_en |-> mode == MODE_RUN)
		else $error("processor clock outside run");
	a_idle_exit_ok: assert property (mode == MODE_IDLE |=> mode inside {MODE_IDLE, MODE_RUN, MODE_HOLD})
		else $error("idle left other than by wake or reset");
	a_idle_wakes: assert property (mode == MODE_IDLE && int_req |-> ##[1:2] mode == MODE_RUN)
		else $error("interrupt did not end idle");
	a_pd_wins: assert property (pwr_wr && reg_wdata[PWR_PD_BIT] |-> ##[1:2] mode == MODE_PDOWN)
		else $error("power-down not entered");
	a_sleep_enters_idle: assert property (pwr_wr && reg_wdata[1:0] == 2'b01 && !int_req |-> ##[1:2] mode == MODE_IDLE)
		else $error("idle not entered");
	a_hold_means_reset: assert property (sys_rst == (mode == MODE_HOLD))
		else $error("reset output disagrees with hold");
	a_pd_stays: assert property (mode == MODE_PDOWN |=> mode inside {MODE_PDOWN, MODE_WAKE, MODE_HOLD})
		else $error("power-down left without wake");
	a_wake_count: assert property (mode == MODE_RUN && $past(mode) == MODE_WAKE
		|-> $past(wake_len_r) >= WAKE_CNT - 1 && $past(wake_len_r) <= WAKE_CNT + 1)
		else $error("wake count wrong length");
endmodule : pmcg_properties

// ==== sim/tb_top.sv ====
// Self-checking bench for the power unit and its controller
`timescale 1ns/1ps
module tb_top;
	import pmcg_pkg::*;
	localparam int WK = 4;
	logic        core_clk_i = 1'b0;
	logic        srst_i = 1'b1;
	logic        ext_wake = 1'b0, cal_wake = 1'b0, cal_32k = 1'b0, pin_rst = 1'b0, wdt_rst = 1'b0;
	logic        osc_en, base_en, mult_off, pin_hold, mult_seen;
	logic        osc_rdy = 1'b1, init_dn = 1'b1;
	logic [31:0] periph;
	logic [7:0]  avs_addr = 8'h00;
	logic        avs_rd = 1'b0, avs_wr = 1'b0, avs_wait, int_req = 1'b0, proc_en, sys_rst_h, conv_pwr;
	logic [31:0] avs_wd = 32'h0, avs_rdata, rdv, gates = GATE_RESET, v;
	int          failures = 0, checked = 0, n;
	int          bits [12] = '{GATE_TIM0, GATE_TIM1, GATE_SER0, GATE_SER1, GATE_TW0, GATE_SPI,
		GATE_CAL, GATE_SSP, GATE_CONV, GATE_TW1, GATE_TIM2, GATE_TIM3};

	pmcg_if lk ();
	pmcg_device #(.WAKE_CNT(WK)) u_pmcg_device (.core_clk_i(core_clk_i), .srst_i(srst_i), .lk(lk),
		.ext_wake_i(ext_wake), .cal_wake_i(cal_wake), .cal_32k_i(cal_32k), .pin_rst_i(pin_rst),
		.wdt_rst_i(wdt_rst), .osc_ready_i(osc_rdy), .init_done_i(init_dn), .osc_en_o(osc_en),
		.base_clk_en_o(base_en), .periph_clk_en_o(periph), .mult_off_o(mult_off), .pin_hold_o(pin_hold));
	pmcg_host u_pmcg_host (.core_clk_i(core_clk_i), .srst_i(srst_i), .lk(lk), .avs_address_i(avs_addr),
		.avs_read_i(avs_rd), .avs_write_i(avs_wr), .avs_writedata_i(avs_wd), .avs_readdata_o(avs_rdata),
		.avs_waitrequest_o(avs_wait), .int_req_i(int_req), .proc_clk_en_o(proc_en),
		.sys_rst_o(sys_rst_h), .conv_power_o(conv_pwr));
	pmcg_properties #(.WAKE_CNT(WK)) u_pmcg_properties (.core_clk_i(core_clk_i), .srst_i(srst_i),
		.reg_sel(lk.reg_sel), .reg_wr(lk.reg_wr), .reg_addr(lk.reg_addr), .reg_wdata(lk.reg_wdata),
		.reg_ack(lk.reg_ack), .int_req(lk.int_req), .processor_clock_en(lk.processor_clock_en),
		.sys_rst(lk.sys_rst), .mode(lk.mode));

	initial
		forever #4 core_clk_i = ~core_clk_i;
	// The entry pulse lasts one cycle, so latch it for a later look
	always @(posedge core_clk_i)
		if (mult_off === 1'b1)
			mult_seen <= 1'b1;

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			failures++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic cyc(input int k);
		repeat (k) @(posedge core_clk_i);
	endtask : cyc
	// One Avalon access; the trailing edge keeps strobes from being reassigned in one step
	task automatic av(input logic [7:0] a, input logic w, input logic [31:0] d);
		avs_addr <= a;
		avs_wr <= w;
		avs_rd <= !w;
		avs_wd <= d;
		@(posedge core_clk_i);
		while (avs_wait !== 1'b0)
			@(posedge core_clk_i);
		rdv = avs_rdata;
		avs_wr <= 1'b0;
		avs_rd <= 1'b0;
		@(posedge core_clk_i);
	endtask : av
	task automatic link(input logic g, input logic w, input logic [31:0] d);
		av(AV_WDATA, 1'b1, d);
		av(AV_CTRL, 1'b1, {29'h0, g, w, 1'b1});
		av(AV_STATUS, 1'b0, 32'h0);
		while (rdv[0] !== 1'b0)
			av(AV_STATUS, 1'b0, 32'h0);
		av(AV_RDATA, 1'b0, 32'h0);
	endtask : link
	task automatic gate_set(input logic [31:0] g);
		link(1'b1, 1'b1, g);
		chk(rdv, gates);
		chk(periph, g & GATE_MASK);
		chk(32'(base_en), 32'h1);
		gates = g;
	endtask : gate_set
	task automatic wait_mode(input pmcg_mode_type m);
		while (lk.mode !== m)
			@(posedge core_clk_i);
	endtask : wait_mode
	task automatic conclude();
		$display("checks %0d mismatches %0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : conclude

	initial
	begin
		#480000;
		failures++;
		$display("mismatch at %0t: watchdog expired", $time);
		conclude();
	end

	initial
	begin
		v = $urandom(75201);
		cyc(5);
		srst_i <= 1'b0;
		wait_mode(MODE_RUN);
		link(1'b1, 1'b0, 32'h0);
		chk(rdv, GATE_RESET);
		link(1'b0, 1'b0, 32'h0);
		chk(rdv, 32'h0);
		chk(periph, GATE_RESET & GATE_MASK);
		$display("test reset values done");
		foreach (bits[i])
			gate_set(32'h1 << bits[i]);
		for (int i = 0; i < 8; i++)
			gate_set(i == 0 ? 32'h0 : i == 1 ? GATE_MASK : $urandom() & GATE_MASK);
		$display("test gate mapping done");
		gate_set(32'h0);
		av(AV_CONV, 1'b1, 32'h1);
		chk(32'(conv_pwr), 32'h0);
		gate_set(32'h1 << GATE_CONV);
		av(AV_CONV, 1'b1, 32'h1);
		chk(32'(conv_pwr), 32'h1);
		// A gate write that would stop the powered converter keeps its clock on
		link(1'b1, 1'b1, 32'h0);
		chk(rdv, gates);
		chk(periph, 32'h1 << GATE_CONV);
		gates = 32'h1 << GATE_CONV;
		av(AV_CONV, 1'b1, 32'h0);
		$display("test converter order done");
		for (int s = 0; s < 2; s++)
		begin
			link(1'b0, 1'b1, 32'h1);
			wait_mode(MODE_IDLE);
			cyc(10);
			chk(32'(proc_en), 32'h0);
			chk(periph, gates & GATE_MASK);
			if (s)
				ext_wake <= 1'b1;
			else
				int_req <= 1'b1;
			wait_mode(MODE_RUN);
			int_req <= 1'b0;
			ext_wake <= 1'b0;
			link(1'b0, 1'b0, 32'h0);
			chk(rdv, 32'h0);
			chk(32'(proc_en), 32'h1);
		end
		$display("test idle done");
		for (int s = 0; s < 2; s++)
		begin
			mult_seen = 1'b0;
			link(1'b0, 1'b1, s ? 32'h2 : 32'h3);
			wait_mode(MODE_PDOWN);
			cal_wake <= 1'b1;
			cyc(10);
			chk(32'({osc_en, base_en, pin_hold, mult_seen}), 32'h3);
			chk(periph, 32'h0);
			chk(32'(lk.mode), 32'(MODE_PDOWN));
			if (s)
				ext_wake <= 1'b1;
			else
				cal_32k <= 1'b1;
			wait_mode(MODE_RUN);
			ext_wake <= 1'b0;
			cal_wake <= 1'b0;
			cal_32k <= 1'b0;
			link(1'b0, 1'b0, 32'h0);
			chk(rdv, 32'h0);
			link(1'b1, 1'b0, 32'h0);
			chk(rdv, gates);
			chk(32'(osc_en), 32'h1);
		end
		$display("test power-down done");
		// Last pass leaves oscillator and init ready so the hold count is timed alone
		for (int s = 0; s < 3; s++)
		begin
			gate_set(32'h0);
			if (s == 1)
				wdt_rst <= 1'b1;
			else
				pin_rst <= 1'b1;
			osc_rdy <= (s != 0);
			init_dn <= (s != 1);
			cyc(1);
			pin_rst <= 1'b0;
			wdt_rst <= 1'b0;
			cyc(1);
			chk(32'(lk.mode), 32'(MODE_HOLD));
			if (s != 2)
			begin
				cyc(2 * WK);
				chk(32'(lk.mode), 32'(MODE_HOLD));
				chk(32'(sys_rst_h), 32'h1);
				osc_rdy <= 1'b1;
				init_dn <= 1'b1;
			end
			n = 0;
			while (lk.mode !== MODE_RUN)
			begin
				n++;
				@(posedge core_clk_i);
			end
			chk(32'(n), (s == 2) ? 32'(WK + 1) : 32'h2);
			link(1'b1, 1'b0, 32'h0);
			chk(rdv, GATE_RESET);
			chk(32'(sys_rst_h), 32'h0);
			gates = GATE_RESET;
		end
		$display("test reset sources done");
		conclude();
	end
endmodule : tb_top
